// File: sbus_periph_model.sv
/* Peripheral on one chip select that ends its own cycles.
   Assumes the bench resolves shared lines, with pull-ups on done/error. */
`timescale 1ns/10ps

module sbus_periph_model (
    input wire logic mclk_i,          // Bus clock
    input wire logic reset_i,         // Sync reset
    input wire logic sel_n_i,         // Its chip select
    input wire logic rw_i,            // Direction, high read
    input wire logic [31:0] data_i,   // Data lines
    input wire logic [7:0] dly_i,     // Cycles before ending
    input wire logic [1:0] mode_i,    // 0 done, 1 error, 2 both
    output logic done_n_o,            // Done out
    output logic done_oe_o,           // Done drive
    output logic err_n_o,             // Error out
    output logic err_oe_o,            // Error drive
    output logic [31:0] data_o,       // Read data
    output logic data_oe_o            // Data drive
);
    logic [2:0] st_q;
    logic [7:0] cnt_q;
    // ----------------
    // Termination
    // ----------------
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            st_q <= 3'h0;
        end else begin
            case (st_q)
                3'h0: if (!sel_n_i) begin
                    st_q <= 3'h1;
                    cnt_q <= 8'h00;
                end
                3'h1: if (sel_n_i) st_q <= 3'h0;
                    else if (cnt_q == dly_i) st_q <= 3'h2;
                    else cnt_q <= cnt_q + 8'h01;
                3'h2: begin
                    st_q <= 3'h3;
                    if (!rw_i) data_o <= data_i;
                end
                3'h3: st_q <= 3'h4;
                default: if (sel_n_i) st_q <= 3'h0;
            endcase
        end
    end
    // Low one cycle, high one cycle, then released
    assign done_oe_o = (st_q == 3'h2 || st_q == 3'h3) && mode_i != 2'h1;
    assign err_oe_o = (st_q == 3'h2 || st_q == 3'h3) && mode_i != 2'h0;
    assign done_n_o = st_q != 3'h2;
    assign err_n_o = st_q != 3'h2;
    assign data_oe_o = !sel_n_i && rw_i;
endmodule : sbus_periph_model

// File: sbus_port.sv
/*
 * External system bus port with five chip selects, page-mode DRAM and
 * SDRAM strobes, static write/output strobes and cycle termination.
 * Assumes one internal requester holding its request until answered,
 * and pull-ups on the termination lines when nobody drives them.
 */
// Behaviour
// - All bus pins launch and sample on the one bus clock edge.
// - Drive a 28-bit address bus for the selected peripheral.
// - Drive 32-bit data on writes, sample it on reads.
// - Four active-low byte-lane enables, low for lanes in the cycle.
// - Transfer done low ends the current bus cycle, whoever drives it.
// - A driver of done or error drives it high one cycle before release.
// - Error together with done ends a burst normally, no error.
// - Error without done flags an error and ends any burst.
// - Device both drives and samples the transfer error line.
// - Direction line high for reads, low for writes.
// - Five active-low chip selects, each decoding its own window.
// - Select zero is the boot select used after reset.
// - Each window covers at most 256 Mbytes.
// - Window configuration is held in software-set settings.
// - The decoded select is driven low during its cycle.
// - Selects one to four act as row strobe for page-mode DRAM.
// - Column strobes assert per lane only for DRAM-mode selects.
// - In SDRAM mode strobes 3..1 carry the command, strobe 0 auto-precharge.
// - With no DRAM mode in the cycle all column strobes stay high.
// - Write strobe low only in writes through a chip select.
// - Output enable low only in reads through a chip select.
// - Peripherals may end cycles; the device's own drive is reference only.
`timescale 1ns/10ps

module sbus_port
    import sbus_port_pkg::*;
#(
    parameter int TIMEOUT = TIMEOUT_DEFAULT
) (
    input wire logic mclk_i,                          // Bus clock
    input wire logic reset_i,                         // Sync reset, high
    input wire logic req_i,                           // Cycle request
    input wire logic req_write_i,                     // 1 write, 0 read
    input wire logic [ADDR_W-1:0] req_addr_i,         // Cycle address
    input wire logic [DATA_W-1:0] req_wdata_i,        // Write data
    input wire logic [LANE_N-1:0] req_lanes_i,        // Lanes, high active
    output logic rsp_valid_o,                         // Answer pulse
    output logic rsp_error_o,                         // Answer is error
    output logic [DATA_W-1:0] rsp_rdata_o,            // Read data
    input wire logic [SEL_N*ADDR_W-1:0] cs_base_i,    // Window bases
    input wire logic [SEL_N*ADDR_W-1:0] cs_mask_i,    // Window masks
    input wire logic [SEL_N-1:0] cs_enable_i,         // Select enables
    input wire logic [SEL_N*2-1:0] cs_mode_i,         // Select modes
    input wire logic [SEL_N*WAIT_W-1:0] cs_wait_i,    // Wait states
    output logic boot_window_o,                       // Boot window open
    output logic [ADDR_W-1:0] addr_o,                 // Address out
    output logic addr_oe_o,                           // Address drive
    input wire logic [ADDR_W-1:0] addr_i,             // Address in
    output logic [DATA_W-1:0] data_o,                 // Data out
    output logic data_oe_o,                           // Data drive
    input wire logic [DATA_W-1:0] data_i,             // Data in
    output logic [LANE_N-1:0] byte_lane_n_o,          // Lane enables
    output logic byte_lane_oe_o,                      // Lane drive
    input wire logic [LANE_N-1:0] byte_lane_n_i,      // Lane enables in
    output logic read_write_o,                        // Direction out
    output logic read_write_oe_o,                     // Direction drive
    input wire logic read_write_i,                    // Direction in
    output logic transfer_done_n_o,                   // Done out
    output logic transfer_done_oe_o,                  // Done drive
    input wire logic transfer_done_n_i,               // Done in
    output logic transfer_error_n_o,                  // Error out
    output logic transfer_error_oe_o,                 // Error drive
    input wire logic transfer_error_n_i,              // Error in
    output logic [SEL_N-1:0] select_n_o,              // Chip selects
    output logic [LANE_N-1:0] column_strobe_n_o,      // Column strobes
    output logic write_strobe_n_o,                    // Write strobe
    output logic out_enable_n_o                       // Output enable
);

    localparam int TMO_W = $clog2(TIMEOUT + 1);

    port_state_e state_q, state_d;
    logic [SEL_N-1:0] hit;
    logic any_hit;
    logic boot_q;
    logic [SEL_N-1:0] sel_q;
    logic [1:0] mode_q;
    logic [WAIT_W-1:0] wait_q;
    logic write_q;
    logic [ADDR_W-1:0] addr_q;
    logic [DATA_W-1:0] wdata_q;
    logic [LANE_N-1:0] lanes_q;
    logic [TMO_W-1:0] cnt_q;
    logic first_q;
    logic own_err_q;
    logic ext_end, ext_err, own_end, own_err, tmo;

    // --------------------------------------------------------------
    // Decode
    // --------------------------------------------------------------
    sbus_select_decode #(.N(SEL_N)) u_decode (
        .addr_i(req_addr_i),
        .base_i(cs_base_i),
        .mask_i(cs_mask_i),
        .enable_i(cs_enable_i),
        .boot_i(boot_q),
        .hit_o(hit),
        .any_o(any_hit)
    );

    // Boot window closes once software enables select 0
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            boot_q <= 1'b1;
        end else if (cs_enable_i[0]) begin
            boot_q <= 1'b0;
        end
    end

    // --------------------------------------------------------------
    // Cycle control
    // --------------------------------------------------------------
    // Peripheral termination, sampled on the clock edge
    assign ext_end = !transfer_done_n_i;
    assign ext_err = !transfer_error_n_i && transfer_done_n_i;
    assign tmo = (wait_q == WAIT_EXTERNAL) && (cnt_q == TMO_W'(TIMEOUT));
    assign own_end = (wait_q != WAIT_EXTERNAL) && (cnt_q == TMO_W'(wait_q));
    assign own_err = tmo;

    always_comb begin
        state_d = state_q;
        unique case (state_q)
            ST_IDLE: begin
                if (req_i && any_hit) begin
                    state_d = ST_ADDR;
                end
            end
            ST_ADDR: state_d = ST_ACCESS;
            ST_ACCESS: begin
                if (ext_end || ext_err) begin
                    state_d = ST_IDLE;
                end else if (own_end || own_err) begin
                    state_d = ST_TERM_LOW;
                end
            end
            ST_TERM_LOW: state_d = ST_TERM_HIGH;
            ST_TERM_HIGH: state_d = ST_IDLE;
        endcase
    end

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            state_q <= ST_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            sel_q <= '0;
            mode_q <= MODE_STATIC;
            wait_q <= WAIT_ZERO;
            write_q <= 1'b0;
            addr_q <= ADDR_RESET;
            wdata_q <= DATA_RESET;
            lanes_q <= '0;
        end else if (state_q == ST_IDLE && req_i && any_hit) begin
            sel_q <= hit;
            mode_q <= MODE_STATIC;
            wait_q <= WAIT_ZERO;
            for (int i = 0; i < SEL_N; i++) begin
                if (hit[i]) begin
                    mode_q <= cs_mode_i[i*2 +: 2];
                    wait_q <= cs_wait_i[i*WAIT_W +: WAIT_W];
                end
            end
            write_q <= req_write_i;
            addr_q <= req_addr_i;
            wdata_q <= req_wdata_i;
            lanes_q <= req_lanes_i;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            cnt_q <= '0;
            first_q <= 1'b0;
        end else begin
            first_q <= (state_q == ST_ADDR);
            if (state_q == ST_ACCESS) begin
                cnt_q <= cnt_q + 1'b1;
            end else begin
                cnt_q <= '0;
            end
        end
    end

    // --------------------------------------------------------------
    // Answer
    // --------------------------------------------------------------
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            rsp_valid_o <= 1'b0;
            rsp_error_o <= 1'b0;
            rsp_rdata_o <= DATA_RESET;
        end else begin
            rsp_valid_o <= 1'b0;
            rsp_error_o <= 1'b0;
            if (state_q == ST_IDLE && req_i && !any_hit) begin
                // Unmapped address: refused without a bus cycle
                rsp_valid_o <= 1'b1;
                rsp_error_o <= 1'b1;
            end else if (state_q == ST_ACCESS && (ext_end || ext_err)) begin
                rsp_valid_o <= 1'b1;
                rsp_error_o <= ext_err;
                rsp_rdata_o <= data_i;
            end else if (state_q == ST_ACCESS && (own_end || own_err)) begin
                rsp_valid_o <= 1'b1;
                rsp_error_o <= own_err;
                rsp_rdata_o <= data_i;
            end
        end
    end

    // --------------------------------------------------------------
    // Pins
    // --------------------------------------------------------------
    // Pins trail the state by one clock so every pin is a flop output.
    logic busy;
    logic page, sdram;
    assign busy = (state_q == ST_ADDR) || (state_q == ST_ACCESS) || (state_q == ST_TERM_LOW);
    assign page = (mode_q == MODE_PAGE_DRAM) && !sel_q[0];
    assign sdram = (mode_q == MODE_SDRAM);

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            addr_o <= ADDR_RESET;
            addr_oe_o <= 1'b1;
            read_write_o <= 1'b1;
            read_write_oe_o <= 1'b1;
            byte_lane_n_o <= LANES_IDLE_N;
            byte_lane_oe_o <= 1'b1;
            data_o <= DATA_RESET;
            data_oe_o <= 1'b0;
        end else begin
            addr_o <= addr_q;
            read_write_o <= busy ? !write_q : 1'b1;
            byte_lane_n_o <= busy ? ~lanes_q : LANES_IDLE_N;
            data_o <= wdata_q;
            data_oe_o <= busy && write_q;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            select_n_o <= SELECTS_IDLE_N;
        end else begin
            select_n_o <= busy ? ~sel_q : SELECTS_IDLE_N;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            column_strobe_n_o <= LANES_IDLE_N;
        end else if (busy && sdram) begin
            // Row activate on address phase, then one column command
            if (state_q == ST_ADDR) begin
                column_strobe_n_o <= {SD_CMD_ACT, 1'b0};
            end else if (first_q) begin
                column_strobe_n_o <= {write_q ? SD_CMD_WRITE : SD_CMD_READ, 1'b1};
            end else begin
                column_strobe_n_o <= {SD_CMD_NOP, 1'b0};
            end
        end else if (busy && page && state_q != ST_ADDR) begin
            column_strobe_n_o <= ~lanes_q;
        end else begin
            column_strobe_n_o <= LANES_IDLE_N;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            write_strobe_n_o <= 1'b1;
            out_enable_n_o <= 1'b1;
        end else begin
            write_strobe_n_o <= !(state_q == ST_ACCESS && write_q
                                  && mode_q == MODE_STATIC);
            out_enable_n_o <= !(state_q == ST_ACCESS && !write_q
                                && mode_q == MODE_STATIC);
        end
    end

    // Own termination: low one cycle, high one cycle, then released
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            transfer_done_n_o <= 1'b1;
            transfer_done_oe_o <= 1'b0;
            transfer_error_n_o <= 1'b1;
            transfer_error_oe_o <= 1'b0;
        end else begin
            transfer_done_n_o <= !(state_q == ST_TERM_LOW && !own_err_q);
            transfer_done_oe_o <= (state_q == ST_TERM_LOW && !own_err_q)
                                  || (state_q == ST_TERM_HIGH && !own_err_q);
            transfer_error_n_o <= !(state_q == ST_TERM_LOW && own_err_q);
            transfer_error_oe_o <= (state_q == ST_TERM_LOW || state_q == ST_TERM_HIGH)
                                   && own_err_q;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            own_err_q <= 1'b0;
        end else if (state_q == ST_ACCESS) begin
            own_err_q <= own_err;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            boot_window_o <= 1'b1;
        end else begin
            boot_window_o <= boot_q;
        end
    end

    // --------------------------------------------------------------
    // Checks
    // --------------------------------------------------------------
    a_done_high_before_release: assert property (@(posedge mclk_i) disable iff (reset_i)
        $fell(transfer_done_oe_o) |-> $past(transfer_done_n_o))
        else $error("done released without a high cycle");
    a_error_high_release: assert property (@(posedge mclk_i) disable iff (reset_i)
        $fell(transfer_error_oe_o) |-> $past(transfer_error_n_o))
        else $error("error released without a high cycle");
    a_ext_done_ends: assert property (@(posedge mclk_i) disable iff (reset_i)
        (state_q == ST_ACCESS && ext_end) |=> rsp_valid_o && !rsp_error_o)
        else $error("external done did not end cleanly");
    a_ext_err_flags: assert property (@(posedge mclk_i) disable iff (reset_i)
        (state_q == ST_ACCESS && ext_err) |=> rsp_valid_o && rsp_error_o)
        else $error("error termination not reported");
    a_dir_follows: assert property (@(posedge mclk_i) disable iff (reset_i)
        (state_q == ST_ACCESS) |=> read_write_o == !write_q)
        else $error("direction wrong");
    a_strobes_idle: assert property (@(posedge mclk_i) disable iff (reset_i)
        (mode_q == MODE_STATIC) |=> column_strobe_n_o == LANES_IDLE_N)
        else $error("column strobe in non-DRAM cycle");
    a_write_strobe_dir: assert property (@(posedge mclk_i) disable iff (reset_i)
        !write_strobe_n_o |-> !read_write_o && select_n_o != SELECTS_IDLE_N)
        else $error("write strobe outside write");
    a_oe_dir: assert property (@(posedge mclk_i) disable iff (reset_i)
        !out_enable_n_o |-> read_write_o && !data_oe_o)
        else $error("output enable outside read");
    a_select_held: assert property (@(posedge mclk_i) disable iff (reset_i)
        (state_q == ST_IDLE && req_i && any_hit) |=> ##1 select_n_o == ~sel_q)
        else $error("select not driven in its cycle");
    a_own_term_time: assert property (@(posedge mclk_i) disable iff (reset_i)
        (state_q == ST_ADDR && cs_wait_i[WAIT_W-1:0] == WAIT_ZERO && sel_q[0]
         && wait_q == WAIT_ZERO && transfer_done_n_i && transfer_error_n_i)
        |=> ##1 state_q == ST_TERM_LOW)
        else $error("zero-wait cycle not terminated");

endmodule : sbus_port

// File: sbus_port_pkg.sv
/*
 * Constants shared by the system bus port: widths, chip-select modes,
 * SDRAM command codes, reset values and the port state encoding.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package sbus_port_pkg;

    localparam int ADDR_W = 28;
    localparam int DATA_W = 32;
    localparam int LANE_N = 4;
    localparam int SEL_N = 5;
    localparam int WAIT_W = 4;

    // Chip-select modes, two bits per select
    localparam logic [1:0] MODE_STATIC = 2'h0;
    localparam logic [1:0] MODE_PAGE_DRAM = 2'h1;
    localparam logic [1:0] MODE_SDRAM = 2'h2;

    // SDRAM command on column strobes 3..1: row, column, write enable
    localparam logic [2:0] SD_CMD_NOP = 3'h7;
    localparam logic [2:0] SD_CMD_ACT = 3'h3;
    localparam logic [2:0] SD_CMD_READ = 3'h5;
    localparam logic [2:0] SD_CMD_WRITE = 3'h4;

    // Wait field value that hands termination to the peripheral
    localparam logic [WAIT_W-1:0] WAIT_EXTERNAL = 4'hF;
    localparam logic [WAIT_W-1:0] WAIT_ZERO = 4'h0;

    localparam logic [ADDR_W-1:0] ADDR_RESET = 28'h0000000;
    localparam logic [DATA_W-1:0] DATA_RESET = 32'h00000000;
    localparam logic [LANE_N-1:0] LANES_IDLE_N = 4'hF;
    localparam logic [SEL_N-1:0] SELECTS_IDLE_N = 5'h1F;
    localparam logic [SEL_N-1:0] SELECT_BOOT = 5'h01;
    localparam int TIMEOUT_DEFAULT = 256;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_ACCESS,
        ST_TERM_LOW,
        ST_TERM_HIGH
    } port_state_e;

endpackage : sbus_port_pkg

// File: sbus_select_decode.sv
/*
 * Chip-select window decoder: one compare per select, lowest index wins.
 * Assumes base and mask are stable while a request is presented.
 */
`timescale 1ns/10ps

module sbus_select_decode
    import sbus_port_pkg::*;
#(
    parameter int N = SEL_N
) (
    input wire logic [ADDR_W-1:0] addr_i,      // Address to decode
    input wire logic [N*ADDR_W-1:0] base_i,    // Window bases, packed
    input wire logic [N*ADDR_W-1:0] mask_i,    // Compared address bits
    input wire logic [N-1:0] enable_i,         // Select enabled
    input wire logic boot_i,                   // Boot window open
    output logic [N-1:0] hit_o,                // One-hot hit
    output logic any_o                         // Some select hit
);

    logic [N-1:0] raw;

    // --------------------------------------------------------------
    // Per-select window compare
    // --------------------------------------------------------------
    // A 28-bit address caps every window at 256 Mbytes.
    for (genvar g = 0; g < N; g++) begin : g_win
        logic [ADDR_W-1:0] b;
        logic [ADDR_W-1:0] m;
        assign b = base_i[g*ADDR_W +: ADDR_W];
        assign m = mask_i[g*ADDR_W +: ADDR_W];
        if (g == 0) begin : g_boot
            // Until configured, select 0 answers everything
            assign raw[g] = enable_i[g] ? (((addr_i ^ b) & m) == '0) : boot_i;
        end else begin : g_norm
            assign raw[g] = enable_i[g] && (((addr_i ^ b) & m) == '0);
        end
    end

    always_comb begin
        hit_o = '0;
        for (int i = N - 1; i >= 0; i--) begin
            if (raw[i]) begin
                hit_o = '0;
                hit_o[i] = 1'b1;
            end
        end
        any_o = |raw;
    end

endmodule : sbus_select_decode

// File: system_bus_chip_select_port_test.sv
/* Bench for the system bus port: request task, peripheral on select 3.
   Assumes pull-ups on done/error and a floating data bus otherwise. */
`timescale 1ns/10ps

module system_bus_chip_select_port_test;
    import sbus_port_pkg::*;
    logic mclk_i, reset_i, req_i, req_write_i, rsp_valid_o, rsp_error_o, boot_window_o;
    logic [ADDR_W-1:0] req_addr_i, addr_o, addr_seen;
    logic [DATA_W-1:0] req_wdata_i, rsp_rdata_o, data_o, bus_d, last_d, m_data, rd;
    logic [LANE_N-1:0] req_lanes_i, byte_lane_n_o, column_strobe_n_o, lane_seen, cas_seen;
    logic [SEL_N*ADDR_W-1:0] cs_base_i, cs_mask_i;
    logic [SEL_N-1:0] cs_enable_i, select_n_o, sel_seen;
    logic [SEL_N*2-1:0] cs_mode_i;
    logic [SEL_N*WAIT_W-1:0] cs_wait_i;
    logic addr_oe_o, data_oe_o, byte_lane_oe_o, read_write_o, read_write_oe_o;
    logic transfer_done_n_o, transfer_done_oe_o, transfer_error_n_o, transfer_error_oe_o;
    logic write_strobe_n_o, out_enable_n_o, m_done_n, m_done_oe, m_err_n, m_err_oe, m_data_oe;
    logic er, we_seen, oe_seen, rw_seen, act_seen, ap_seen, terr_seen, pdo, pdn, peo, pen;
    logic [2:0] cmd_seen;
    logic [7:0] m_dly;
    logic [1:0] m_mode;
    int error_cnt, cmp_count;
    wire done_w = transfer_done_oe_o ? transfer_done_n_o : (m_done_oe ? m_done_n : 1'b1);
    wire err_w = transfer_error_oe_o ? transfer_error_n_o : (m_err_oe ? m_err_n : 1'b1);
    // Undriven data bus shows a changing pattern, never a stale value
    assign bus_d = data_oe_o ? data_o : (m_data_oe ? m_data : ~last_d);

    sbus_port #(.TIMEOUT(8)) u_sbus_port (.mclk_i, .reset_i, .req_i, .req_write_i,
        .req_addr_i, .req_wdata_i, .req_lanes_i, .rsp_valid_o, .rsp_error_o, .rsp_rdata_o,
        .cs_base_i, .cs_mask_i, .cs_enable_i, .cs_mode_i, .cs_wait_i, .boot_window_o,
        .addr_o, .addr_oe_o, .addr_i(addr_o), .data_o, .data_oe_o, .data_i(bus_d),
        .byte_lane_n_o, .byte_lane_oe_o, .byte_lane_n_i(byte_lane_n_o), .read_write_o,
        .read_write_oe_o, .read_write_i(read_write_o), .transfer_done_n_o,
        .transfer_done_oe_o, .transfer_done_n_i(done_w), .transfer_error_n_o,
        .transfer_error_oe_o, .transfer_error_n_i(err_w), .select_n_o, .column_strobe_n_o,
        .write_strobe_n_o, .out_enable_n_o);

    sbus_periph_model u_sbus_periph_model (.mclk_i, .reset_i, .sel_n_i(select_n_o[3]),
        .rw_i(read_write_o), .data_i(bus_d), .dly_i(m_dly), .mode_i(m_mode),
        .done_n_o(m_done_n), .done_oe_o(m_done_oe), .err_n_o(m_err_n), .err_oe_o(m_err_oe),
        .data_o(m_data), .data_oe_o(m_data_oe));

    task automatic chk(input logic ok, input string msg);
        cmp_count++;
        if (ok !== 1'b1) begin
            error_cnt++;
            $display("MISMATCH %0t %s", $time, msg);
        end
    endtask : chk

    task automatic summarize;
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : summarize

    // ----------------
    // Pin monitor
    // ----------------
    always @(posedge mclk_i) begin
        last_d <= bus_d;
        if (select_n_o !== SELECTS_IDLE_N) begin
            sel_seen |= ~select_n_o;
            lane_seen |= ~byte_lane_n_o;
            rw_seen = read_write_o;
            addr_seen = addr_o;
        end
        cas_seen |= ~column_strobe_n_o;
        we_seen |= ~write_strobe_n_o;
        oe_seen |= ~out_enable_n_o;
        terr_seen |= transfer_error_oe_o & ~transfer_error_n_o;
        if (column_strobe_n_o === {SD_CMD_ACT, 1'b0}) act_seen = 1'b1;
        if (column_strobe_n_o[3:1] === SD_CMD_READ
            || column_strobe_n_o[3:1] === SD_CMD_WRITE) begin
            cmd_seen = column_strobe_n_o[3:1];
            ap_seen = column_strobe_n_o[0];
        end
        if (pdo === 1'b1 && transfer_done_oe_o === 1'b0) chk(pdn, "done released low");
        if (peo === 1'b1 && transfer_error_oe_o === 1'b0) chk(pen, "error released low");
        {pdo, pdn, peo, pen} = {transfer_done_oe_o, transfer_done_n_o, transfer_error_oe_o,
            transfer_error_n_o};
    end

    task automatic cyc(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                       input logic [LANE_N-1:0] l);
        int n;
        {sel_seen, lane_seen, cas_seen, cmd_seen} = '0;
        {we_seen, oe_seen, act_seen, ap_seen, terr_seen} = '0;
        {req_i, req_write_i, req_addr_i, req_wdata_i, req_lanes_i} = {1'b1, w, a, d, l};
        n = 0;
        do begin
            @(posedge mclk_i);
            #1;
            n++;
        end while (rsp_valid_o !== 1'b1 && n < 100);
        rd = rsp_rdata_o;
        er = rsp_error_o;
        req_i = 1'b0;
        if (n >= 100) begin
            error_cnt++;
            $display("MISMATCH %0t no answer", $time);
            summarize();
        end
        repeat (4) @(posedge mclk_i);
        #1;
    endtask : cyc

    initial begin
        mclk_i = 1'b0;
        forever #4 mclk_i = ~mclk_i;
    end

    initial begin
        {error_cnt, cmp_count, last_d} = '0;
        {reset_i, req_i, req_write_i, req_addr_i, req_wdata_i, req_lanes_i} = {1'b1, 66'h0};
        {m_dly, m_mode, cs_enable_i} = {8'h02, 2'h0, 5'h00};
        cs_mask_i = {5{28'hF000000}};
        for (int i = 0; i < SEL_N; i++) cs_base_i[i*ADDR_W +: ADDR_W] = {i[3:0], 24'h000000};
        cs_mode_i = {2'h0, MODE_STATIC, MODE_SDRAM, MODE_PAGE_DRAM, MODE_STATIC};
        cs_wait_i = {4'h0, WAIT_EXTERNAL, 4'h1, 4'h1, WAIT_ZERO};
        repeat (10) @(posedge mclk_i);
        #1 reset_i = 1'b0;
        chk(select_n_o === SELECTS_IDLE_N, "idle selects");
        chk(column_strobe_n_o === LANES_IDLE_N, "idle strobes");
        chk(addr_oe_o && byte_lane_oe_o && read_write_oe_o, "sole master drive");
        chk(!transfer_done_oe_o && !transfer_error_oe_o, "termination released");
        cyc(1'b0, 28'h0ABCDE0, '0, 4'hF);
        chk(sel_seen === SELECT_BOOT && boot_window_o === 1'b1, "boot select");
        cs_enable_i = 5'h0F;
        cyc(1'b1, 28'h0000010, 32'hA5A55A5A, 4'h3);
        chk(sel_seen === SELECT_BOOT && addr_seen === 28'h0000010, "static select");
        chk(we_seen === 1'b1 && oe_seen === 1'b0 && rw_seen === 1'b0, "write");
        chk(lane_seen === 4'h3 && cas_seen === 4'h0, "lanes");
        chk(boot_window_o === 1'b0 && er === 1'b0, "boot window");
        cyc(1'b0, 28'h0000014, '0, 4'hF);
        chk(oe_seen === 1'b1 && we_seen === 1'b0 && rw_seen === 1'b1, "read");
        cyc(1'b1, 28'h1000020, '0, 4'h5);
        chk(sel_seen === 5'h02 && cas_seen === 4'h5 && we_seen === 1'b0, "page");
        for (int i = 0; i < 2; i++) begin
            cyc(i[0], 28'h2000040, '0, 4'hF);
            chk(sel_seen === 5'h04 && act_seen === 1'b1 && ap_seen === 1'b1, "sdram");
            chk(cmd_seen === (i == 0 ? SD_CMD_READ : SD_CMD_WRITE), "sdram cmd");
        end
        cyc(1'b1, 28'h3000100, 32'h12345678, 4'hF);
        cyc(1'b0, 28'h3000100, '0, 4'hF);
        chk(rd === 32'h12345678 && er === 1'b0, "external");
        m_mode = 2'h2;
        cyc(1'b0, 28'h3000104, '0, 4'hF);
        chk(er === 1'b0, "done with error");
        m_mode = 2'h1;
        cyc(1'b0, 28'h3000108, '0, 4'hF);
        chk(er === 1'b1, "error end");
        m_dly = 8'h40;
        cyc(1'b0, 28'h300010C, '0, 4'hF);
        chk(er === 1'b1 && terr_seen === 1'b1, "timeout");
        cyc(1'b0, 28'h4000000, '0, 4'hF);
        chk(er === 1'b1 && sel_seen === 5'h00, "unmapped");
        summarize();
    end
endmodule : system_bus_chip_select_port_test
